//--- src/i2cab_defs.svh
`ifndef I2CAB_DEFS_SVH
`define I2CAB_DEFS_SVH

// Byte addresses of the registers on the processor bus.
`define I2CAB_ADDR_ABORT      32'h5000_1380
`define I2CAB_ADDR_DMA_CR     32'h5000_1388
`define I2CAB_ADDR_DMA_TDL    32'h5000_138C
`define I2CAB_ADDR_DMA_RDL    32'h5000_1390
`define I2CAB_ADDR_CTRL       32'h5000_13C0
`define I2CAB_ADDR_ABORT_CLR  32'h5000_13C4

// Abort cause bit positions.
`define I2CAB_B_SEVENBIT_NACK  0
`define I2CAB_B_TENBIT1_NACK   1
`define I2CAB_B_TENBIT2_NACK   2
`define I2CAB_B_DATA_NACK      3
`define I2CAB_B_GCALL_NACK     4
`define I2CAB_B_GCALL_READ     5
`define I2CAB_B_HS_ACKED       6
`define I2CAB_B_SBYTE_ACKED    7
`define I2CAB_B_HS_NORESTART   8
`define I2CAB_B_SBYTE_NORESTRT 9
`define I2CAB_B_TENBIT_RD_NORS 10
`define I2CAB_B_MASTER_DIS     11
`define I2CAB_B_ARBITRATION_LOST_FLAG       12
`define I2CAB_B_SLV_FLUSH      13
`define I2CAB_B_SLV_BUS_LOST   14

// DMA control fields.
`define I2CAB_B_RX_DMA_EN      0
`define I2CAB_B_TX_DMA_EN      1

// Control register fields.
`define I2CAB_B_MASTER_EN      0
`define I2CAB_B_RESTART_ALLOW  1
`define I2CAB_B_TENBIT_MODE    2
`define I2CAB_B_HS_MODE        3
`define I2CAB_B_CMD_SEL_A      4
`define I2CAB_B_GC_OR_SB_SEL   5
`define I2CAB_B_ABORT_CLR      0

// Reset values.
`define I2CAB_RST_ABORT        15'h0000
`define I2CAB_RST_DMA_CR       2'h0
`define I2CAB_RST_WM           5'h00
`define I2CAB_RST_CTRL         6'h00

`define I2CAB_REG_W            16
`define I2CAB_BUS_W            32
`define I2CAB_BE_W             4

`endif

//--- src/i2cab_pkg.sv
`default_nettype none
package i2cab_pkg;

  // Per-cycle strobes and levels from the master and slave engines.
  typedef struct packed {
    logic master_start_req;
    logic master_read_req;
    logic master_tx_pending;
    logic addr_nack;
    logic addr1_nack;
    logic addr2_nack;
    logic data_nack;
    logic addr_acked;
    logic gcall_sent;
    logic next_cmd_read;
    logic gcall_nack;
    logic sbyte_ack;
    logic hs_ack;
    logic slave_read_req;
    logic master_tx_active;
    logic slave_tx_active;
    logic tx_bit;
  } i2cab_engine_t;

  typedef struct packed {
    logic gc_or_sb_sel;
    logic cmd_sel_a;
    logic hs_mode;
    logic tenbit_mode;
    logic restart_allow;
    logic master_en;
  } i2cab_ctrl_t;

  typedef enum logic [1:0] {
    I2CAB_BUS_IDLE,
    I2CAB_BUS_ANSWER
  } i2cab_bus_state_t;

endpackage
`default_nettype wire

//--- src/i2cab_core.sv
// Notes on behaviour
// - Slave losing bus while transmitting sets bits 14 and 12 together.
// - At each SCL rise while sending, sampled SDA must match sent bit.
// - Slave read with stale TX data: set bit 13, interrupt, flush.
// - Bit 12 marks master arbitration loss, or slave loss when 14 set.
// - Master and slave abort flags are recorded independently.
// - Master start attempted while master mode disabled sets bit 11.
// - Ten-bit read without repeated start allowed sets bit 10.
// - START byte request without repeated start allowed sets bit 9.
// - Bit 9 clears one cycle then re-sets if its cause persists.
// - High-speed transfer without repeated start allowed sets bit 8.
// - Acknowledged START byte sets bit 7.
// - Acknowledged high-speed master code sets bit 6.
// - General call followed by a queued read command sets bit 5.
// - General call with no acknowledge sets bit 4.
// - Master data byte unacknowledged after acknowledged address sets bit 3.
// - Ten-bit mode, second address byte not acknowledged sets bit 2.
// - Ten-bit mode, first address byte not acknowledged sets bit 1.
// - Seven-bit mode, address not acknowledged sets bit 0.
// - DMA control holds transmit enable bit 1, receive enable bit 0.
// - TX DMA request when enabled and TX level at or below watermark.
// - RX DMA request when enabled and RX level reaches watermark plus one.
//
// Added by the designer: the Avalon-MM slave port.
`default_nettype none
`include "i2cab_defs.svh"

module i2cab_core #(
  parameter int LVL_W = 6,
  parameter int WM_W  = 5
) (
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  input  wire logic [`I2CAB_BUS_W-1:0]     avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [`I2CAB_BUS_W-1:0]     avs_writedata,
  input  wire logic [`I2CAB_BE_W-1:0]      avs_byteenable,
  output logic      [`I2CAB_BUS_W-1:0]     avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        scl_pin,
  input  wire logic                        sda_pin,
  input  wire i2cab_pkg::i2cab_engine_t    engine,
  input  wire logic [LVL_W-1:0]            tx_fifo_level,
  input  wire logic [LVL_W-1:0]            rx_fifo_level,
  output logic                             transmit_abort_irq,
  output logic                             slave_tx_flush,
  output logic                             master_bus_lost,
  output logic                             slave_bus_lost,
  output logic                             dma_tx_req,
  output logic                             dma_rx_req
);

  // Address compare, used by both the read mux and the write decode.
  // The full byte address is compared, so aliases never decode.
  function automatic logic addr_is(
    input logic [`I2CAB_BUS_W-1:0] a,
    input logic [`I2CAB_BUS_W-1:0] target
  );
    return a == target;
  endfunction

  // Watermark widened to the FIFO level width.
  // Widening first keeps the level compares free of silent truncation.
  function automatic logic [LVL_W-1:0] wm_ext(input logic [WM_W-1:0] wm);
    return LVL_W'(wm);
  endfunction

  // Pin synchronisers and SCL edge finder.
  // The pins are asynchronous to sys_clk, so two flops settle them first.
  // Everything resets to the pulled-up idle level, so that leaving reset
  // on an idle bus never shows a false SCL rise.
  logic scl_m_q;
  logic scl_m_d;
  logic scl_s_q;
  logic scl_s_d;
  logic scl_p_q;
  logic scl_p_d;
  logic sda_m_q;
  logic sda_m_d;
  logic sda_s_q;
  logic sda_s_d;
  logic scl_rise;

  always_comb begin
    scl_m_d = scl_pin;
    scl_s_d = scl_m_q;
    scl_p_d = scl_s_q;
    sda_m_d = sda_pin;
    sda_s_d = sda_m_q;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      scl_m_q <= scl_m_d;
      scl_s_q <= scl_s_d;
      scl_p_q <= scl_p_d;
      sda_m_q <= sda_m_d;
      sda_s_q <= sda_s_d;
    end
  end

  // Only the settled second stage and the third stage feed the edge
  // finder; the first stage may still be metastable.
  // The rise is seen two clock edges after the pin goes high.
  assign scl_rise = scl_s_q & ~scl_p_q;

  // Bus slave: one wait cycle, then the answer and the write together.
  // Read data are captured on the edge that takes the request, so they
  // stand through the whole cycle in which waitrequest is low.
  // Every access costs at least two cycles; that is traded for a
  // registered waitrequest and registered read data.
  i2cab_pkg::i2cab_bus_state_t bus_st_q, bus_st_d;
  logic                    wait_q, wait_d;
  logic [`I2CAB_BUS_W-1:0] rdata_q, rdata_d;
  logic [`I2CAB_BUS_W-1:0] rmux;
  logic                    wr_take;
  logic                    lane0;

  // Software-visible state.
  // Only bits 14:0 of the abort cause are kept; bit 15 reads zero.
  logic [1:0]            dma_cr_q, dma_cr_d;
  logic [WM_W-1:0]       tdl_q, tdl_d;
  logic [WM_W-1:0]       rdl_q, rdl_d;
  i2cab_pkg::i2cab_ctrl_t ctrl_q, ctrl_d;
  logic [14:0]           abort_q, abort_d;
  logic                  clr_req;

  assign wr_take = (bus_st_q == i2cab_pkg::I2CAB_BUS_ANSWER) && avs_write;
  assign lane0   = avs_byteenable[0];

  // Read mux. Unmapped addresses and the unused upper bits read zero,
  // so software may mask nothing when it reads a narrow register.
  always_comb begin
    rmux = '0;
    if (addr_is(avs_address, `I2CAB_ADDR_ABORT)) begin
      rmux[14:0] = abort_q;
    end else if (addr_is(avs_address, `I2CAB_ADDR_DMA_CR)) begin
      rmux[1:0] = dma_cr_q;
    end else if (addr_is(avs_address, `I2CAB_ADDR_DMA_TDL)) begin
      rmux[WM_W-1:0] = tdl_q;
    end else if (addr_is(avs_address, `I2CAB_ADDR_DMA_RDL)) begin
      rmux[WM_W-1:0] = rdl_q;
    end else if (addr_is(avs_address, `I2CAB_ADDR_CTRL)) begin
      rmux[5:0] = ctrl_q;
    end
  end

  // The answer state lasts one cycle; the master must release after it.
  always_comb begin
    bus_st_d = bus_st_q;
    wait_d   = wait_q;
    rdata_d  = rdata_q;
    case (bus_st_q)
      i2cab_pkg::I2CAB_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_st_d = i2cab_pkg::I2CAB_BUS_ANSWER;
          wait_d   = 1'b0;
          rdata_d  = avs_read ? rmux : '0;
        end
      end
      i2cab_pkg::I2CAB_BUS_ANSWER: begin
        bus_st_d = i2cab_pkg::I2CAB_BUS_IDLE;
        wait_d   = 1'b1;
      end
      default: begin
        bus_st_d = i2cab_pkg::I2CAB_BUS_IDLE;
        wait_d   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus_st_q <= i2cab_pkg::I2CAB_BUS_IDLE;
      wait_q   <= 1'b1;
      rdata_q  <= '0;
    end else begin
      bus_st_q <= bus_st_d;
      wait_q   <= wait_d;
      rdata_q  <= rdata_d;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;

  // Configuration registers; unmapped writes fall through untouched.
  // Every field lives in byte lane 0, so a write whose lane 0 is not
  // enabled changes nothing at all.
  always_comb begin
    dma_cr_d = dma_cr_q;
    tdl_d    = tdl_q;
    rdl_d    = rdl_q;
    ctrl_d   = ctrl_q;
    clr_req  = 1'b0;
    if (wr_take && lane0) begin
      if (addr_is(avs_address, `I2CAB_ADDR_DMA_CR)) begin
        dma_cr_d = avs_writedata[1:0];
      end else if (addr_is(avs_address, `I2CAB_ADDR_DMA_TDL)) begin
        tdl_d = avs_writedata[WM_W-1:0];
      end else if (addr_is(avs_address, `I2CAB_ADDR_DMA_RDL)) begin
        rdl_d = avs_writedata[WM_W-1:0];
      end else if (addr_is(avs_address, `I2CAB_ADDR_CTRL)) begin
        ctrl_d = avs_writedata[5:0];
      end else if (addr_is(avs_address, `I2CAB_ADDR_ABORT_CLR)) begin
        clr_req = avs_writedata[`I2CAB_B_ABORT_CLR];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dma_cr_q <= `I2CAB_RST_DMA_CR;
      tdl_q    <= `I2CAB_RST_WM;
      rdl_q    <= `I2CAB_RST_WM;
      ctrl_q   <= `I2CAB_RST_CTRL;
    end else begin
      dma_cr_q <= dma_cr_d;
      tdl_q    <= tdl_d;
      rdl_q    <= rdl_d;
      ctrl_q   <= ctrl_d;
    end
  end

  // Abort cause collection.
  logic [14:0] set_v;
  logic        lost_m;
  logic        lost_s;
  logic        stale_rd;
  logic        sb_cause;
  logic        irq_d;
  logic        irq_q;
  logic        flush_d;
  logic        flush_q;
  logic        mlost_d;
  logic        mlost_q;
  logic        slost_d;
  logic        slost_q;

  // Only the engine that is driving SDA can lose the bus on a bit.
  // Both roles compare against the same tx_bit; the engines guarantee
  // that only one of them drives SDA in any bit slot.
  // The pulses tell the engines to stop driving at once.
  assign lost_m = scl_rise && engine.master_tx_active &&
                  (sda_s_q != engine.tx_bit);
  assign lost_s = scl_rise && engine.slave_tx_active &&
                  (sda_s_q != engine.tx_bit);
  // A stale read flushes the transmit FIFO through slave_tx_flush; the
  // interrupt tells software why the queued bytes vanished.
  // The START byte cause is a level, so it persists until fixed.
  assign stale_rd = engine.slave_read_req && (tx_fifo_level != '0);
  assign sb_cause = engine.master_tx_pending && !ctrl_q.restart_allow &&
                    ctrl_q.cmd_sel_a && ctrl_q.gc_or_sb_sel;

  // Each cause sets its own bit, except that both bus losses set bit 12, so master and slave causes can coexist.
  // Mode qualifiers come from the control register, not from the
  // engines, so a wrongly flagged strobe in the other mode is ignored.
  // The level causes set their bit in every cycle that they hold.
  always_comb begin
    set_v = '0;
    set_v[`I2CAB_B_SLV_BUS_LOST] = lost_s;
    set_v[`I2CAB_B_ARBITRATION_LOST_FLAG]     = lost_m | lost_s;
    set_v[`I2CAB_B_SLV_FLUSH]    = stale_rd;
    set_v[`I2CAB_B_MASTER_DIS]   = engine.master_start_req &&
                                   !ctrl_q.master_en;
    set_v[`I2CAB_B_TENBIT_RD_NORS] = engine.master_read_req &&
                                     ctrl_q.tenbit_mode &&
                                     !ctrl_q.restart_allow;
    set_v[`I2CAB_B_SBYTE_NORESTRT] = sb_cause;
    set_v[`I2CAB_B_HS_NORESTART] = engine.master_tx_pending &&
                                   ctrl_q.hs_mode &&
                                   !ctrl_q.restart_allow;
    set_v[`I2CAB_B_SBYTE_ACKED]  = engine.sbyte_ack;
    set_v[`I2CAB_B_HS_ACKED]     = engine.hs_ack && ctrl_q.hs_mode;
    set_v[`I2CAB_B_GCALL_READ]   = engine.gcall_sent &&
                                   engine.next_cmd_read;
    set_v[`I2CAB_B_GCALL_NACK]   = engine.gcall_nack;
    set_v[`I2CAB_B_DATA_NACK]    = engine.data_nack &&
                                   engine.addr_acked;
    set_v[`I2CAB_B_TENBIT2_NACK] = engine.addr2_nack &&
                                   ctrl_q.tenbit_mode;
    set_v[`I2CAB_B_TENBIT1_NACK] = engine.addr1_nack &&
                                   ctrl_q.tenbit_mode;
    set_v[`I2CAB_B_SEVENBIT_NACK] = engine.addr_nack &&
                                    !ctrl_q.tenbit_mode;
  end

  // A clear of bit 9 wins for one cycle even while its cause persists;
  // every other bit keeps an event that lands on the clear cycle.
  // Losing an abort cause to a badly timed clear would hide a failed
  // transfer from software, so set wins there.
  always_comb begin
    abort_d = abort_q | set_v;
    if (clr_req) begin
      abort_d = set_v;
      abort_d[`I2CAB_B_SBYTE_NORESTRT] = 1'b0;
    end
    irq_d   = stale_rd;
    flush_d = stale_rd;
    mlost_d = lost_m;
    slost_d = lost_s;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      abort_q <= `I2CAB_RST_ABORT;
      irq_q   <= 1'b0;
      flush_q <= 1'b0;
      mlost_q <= 1'b0;
      slost_q <= 1'b0;
    end else begin
      abort_q <= abort_d;
      irq_q   <= irq_d;
      flush_q <= flush_d;
      mlost_q <= mlost_d;
      slost_q <= slost_d;
    end
  end

  // All outputs come straight from flops, so downstream logic sees
  // clean single-cycle pulses.
  assign transmit_abort_irq = irq_q;
  assign slave_tx_flush     = flush_q;
  assign master_bus_lost    = mlost_q;
  assign slave_bus_lost     = slost_q;

  // DMA request lines follow the FIFO levels with one cycle of latency.
  // The latency is traded for registered outputs; the DMA controller
  // may see one request too many and must tolerate that.
  // The receive sum is one bit wider, so a watermark of 31 cannot wrap.
  logic dtx_d;
  logic dtx_q;
  logic drx_d;
  logic drx_q;

  always_comb begin
    dtx_d = dma_cr_q[`I2CAB_B_TX_DMA_EN] &&
            (tx_fifo_level <= wm_ext(tdl_q));
    drx_d = dma_cr_q[`I2CAB_B_RX_DMA_EN] &&
            ({1'b0, rx_fifo_level} >=
             ({1'b0, wm_ext(rdl_q)} + (LVL_W+1)'(1)));
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dtx_q <= 1'b0;
      drx_q <= 1'b0;
    end else begin
      dtx_q <= dtx_d;
      drx_q <= drx_d;
    end
  end

  assign dma_tx_req = dtx_q;
  assign dma_rx_req = drx_q;

endmodule
`default_nettype wire

//--- bench/i2cab_sva.sv
`default_nettype none
module i2cab_sva #(
  parameter int LVL_W = 6
) (
  input wire logic                     sys_clk,
  input wire logic                     reset,
  input wire i2cab_pkg::i2cab_engine_t engine,
  input wire logic [LVL_W-1:0]         tx_fifo_level,
  input wire logic [LVL_W-1:0]         rx_fifo_level,
  input wire logic                     transmit_abort_irq,
  input wire logic                     slave_tx_flush,
  input wire logic                     master_bus_lost,
  input wire logic                     slave_bus_lost,
  input wire logic                     dma_tx_req,
  input wire logic                     dma_rx_req
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence s_stale;
    engine.slave_read_req && tx_fifo_level != '0;
  endsequence
  sequence s_stale_once;
    s_stale ##1 !engine.slave_read_req;
  endsequence
  a_stale_irq: assert property (s_stale |=> transmit_abort_irq)
    else $error("stale read gave no irq");
  a_irq_single: assert property (
    s_stale_once |=> !transmit_abort_irq)
    else $error("irq longer than one cycle");
  a_irq_flush: assert property (
    transmit_abort_irq == slave_tx_flush)
    else $error("irq and flush apart");
  a_irq_cause: assert property (
    transmit_abort_irq |-> $past(engine.slave_read_req))
    else $error("irq without slave read");
  a_mst_lost_role: assert property (
    master_bus_lost |-> $past(engine.master_tx_active))
    else $error("master loss while idle");
  a_slv_lost_role: assert property (
    slave_bus_lost |-> $past(engine.slave_tx_active))
    else $error("slave loss while idle");
  a_tx_dma_high: assert property (
    tx_fifo_level > 31 |=> !dma_tx_req)
    else $error("tx request above any watermark");
  a_rx_dma_empty: assert property (
    rx_fifo_level == '0 |=> !dma_rx_req)
    else $error("rx request with empty fifo");
endmodule
`default_nettype wire

//--- bench/i2cab_remote.sv
`default_nettype none
module i2cab_remote (
  input wire logic go,
  input wire logic bit_val,
  output var logic scl,
  output var logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus rests at the pull-up level on both lines.
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // One bit frame with a 400 ns clock; sda may disagree on purpose.
  // The frame starts off the sys_clk edge so no pin changes on a sample.
  always @(posedge go) begin
    #10 scl = 1'b0;
    #100 sda = bit_val;
    #100 scl = 1'b1;
    #200 scl = 1'b0;
    #100 sda = 1'b1;
    #100 scl = 1'b1;
  end
endmodule
`default_nettype wire

//--- bench/i2c_tx_abort_and_dma_request_tb.sv
`default_nettype none
`include "i2cab_defs.svh"
module i2c_tx_abort_and_dma_request_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     sys_clk = 1'b0;
  logic                     reset = 1'b1;
  logic [31:0]              av_a = '0;
  logic [31:0]              av_d = '0;
  logic                     av_r = 1'b0;
  logic                     av_w = 1'b0;
  logic [31:0]              avs_readdata;
  logic                     avs_waitrequest;
  logic                     scl, sda, irq, flush, m_lost, s_lost, dtx, drx;
  i2cab_pkg::i2cab_engine_t eng = '0;
  logic [5:0]               tx_lvl = 6'h03;
  logic [5:0]               rx_lvl = 6'h00;
  logic                     go = 1'b0;
  logic                     pbit = 1'b1;
  logic [3:0]               av_be = 4'hF;
  int                       mismatches = 0;
  int                       checked = 0;
  int                       icnt = 0;
  int                       mcnt = 0;
  int                       scnt = 0;

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    icnt <= icnt + int'(irq && flush);
    mcnt <= mcnt + int'(m_lost);
    scnt <= scnt + int'(s_lost);
  end

  i2cab_core DUT (
    .sys_clk(sys_clk), .reset(reset), .avs_address(av_a),
    .avs_read(av_r), .avs_write(av_w), .avs_writedata(av_d),
    .avs_byteenable(av_be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_pin(scl), .sda_pin(sda),
    .engine(eng), .tx_fifo_level(tx_lvl), .rx_fifo_level(rx_lvl),
    .transmit_abort_irq(irq), .slave_tx_flush(flush),
    .master_bus_lost(m_lost), .slave_bus_lost(s_lost),
    .dma_tx_req(dtx), .dma_rx_req(drx));
  i2cab_remote u_remote (.go(go), .bit_val(pbit), .scl(scl), .sda(sda));

  task automatic summarize();
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, s);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // Request rises after an edge and holds until waitrequest is seen low.
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    av_a <= a;
    av_d <= {16'h0000, d};
    av_w <= w;
    av_r <= !w;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    av_w <= 1'b0;
    av_r <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      summarize();
    end
  endtask

  task automatic clr_chk();
    logic [31:0] q;
    bus(1'b1, `I2CAB_ADDR_ABORT_CLR, 16'h0001, q);
    bus(1'b0, `I2CAB_ADDR_ABORT, 16'h0000, q);
    chk("abort_cleared", 32'h0, q);
  endtask

  task automatic flag(input logic [5:0] c, input logic [16:0] e,
                      input logic [15:0] x);
    logic [31:0] q;
    int i0;
    i0 = icnt;
    bus(1'b1, `I2CAB_ADDR_CTRL, {10'h000, c}, q);
    eng <= i2cab_pkg::i2cab_engine_t'(e);
    @(posedge sys_clk);
    eng <= '0;
    bus(1'b0, `I2CAB_ADDR_ABORT, 16'h0000, q);
    chk("abort", {16'h0000, x}, q);
    chk("irq_count", 32'(x[13]), 32'(icnt - i0));
    clr_chk();
  endtask

  task automatic persist();
    logic [31:0] q;
    bus(1'b1, `I2CAB_ADDR_CTRL, 16'h0030, q);
    eng <= i2cab_pkg::i2cab_engine_t'(17'h04000);
    bus(1'b1, `I2CAB_ADDR_ABORT_CLR, 16'h0001, q);
    bus(1'b0, `I2CAB_ADDR_ABORT, 16'h0000, q);
    chk("bit9_reset", 32'h200, q);
    bus(1'b1, `I2CAB_ADDR_CTRL, 16'h0032, q);
    clr_chk();
    eng <= '0;
  endtask

  task automatic dma(input logic [1:0] cr, input logic [5:0] tl, rl,
                     input logic et, er);
    logic [31:0] q;
    bus(1'b1, `I2CAB_ADDR_DMA_CR, {14'h0000, cr}, q);
    tx_lvl <= tl;
    rx_lvl <= rl;
    repeat (2) @(posedge sys_clk);
    chk("dma_tx_req", {31'h0, et}, {31'h0, dtx});
    chk("dma_rx_req", {31'h0, er}, {31'h0, drx});
    bus(1'b0, `I2CAB_ADDR_DMA_CR, 16'h0000, q);
    chk("dma_cr", {30'h0, cr}, q);
  endtask

  task automatic lost(input logic [16:0] e, input logic b,
                      input logic [15:0] x, input int em, es);
    logic [31:0] q;
    int m0;
    int s0;
    m0 = mcnt;
    s0 = scnt;
    eng <= i2cab_pkg::i2cab_engine_t'(e);
    pbit <= b;
    go <= 1'b1;
    repeat (14) @(posedge sys_clk);
    eng <= '0;
    go <= 1'b0;
    bus(1'b0, `I2CAB_ADDR_ABORT, 16'h0000, q);
    chk("lost_abort", {16'h0000, x}, q);
    chk("master_lost", 32'(em), 32'(mcnt - m0));
    chk("slave_lost", 32'(es), 32'(scnt - s0));
    clr_chk();
  endtask

  task automatic regs();
    logic [31:0] q;
    bus(1'b0, `I2CAB_ADDR_DMA_CR, 16'h0000, q);
    chk("dma_cr_reset", 32'h0, q);
    bus(1'b0, `I2CAB_ADDR_DMA_TDL, 16'h0000, q);
    chk("tdl_reset", 32'h0, q);
    bus(1'b1, `I2CAB_ADDR_ABORT, 16'hFFFF, q);
    bus(1'b0, `I2CAB_ADDR_ABORT, 16'h0000, q);
    chk("abort_ro", 32'h0, q);
    bus(1'b0, 32'h5000_1384, 16'h0000, q);
    chk("unmapped", 32'h0, q);
    bus(1'b1, `I2CAB_ADDR_DMA_TDL, 16'h0005, q);
    bus(1'b1, `I2CAB_ADDR_DMA_RDL, 16'h0002, q);
    bus(1'b0, `I2CAB_ADDR_DMA_TDL, 16'h0000, q);
    chk("tdl", 32'h5, q);
    av_be <= 4'hE;
    bus(1'b1, `I2CAB_ADDR_DMA_TDL, 16'h001F, q);
    av_be <= 4'hF;
    bus(1'b0, `I2CAB_ADDR_DMA_TDL, 16'h0000, q);
    chk("tdl_lane0_off", 32'h5, q);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    regs();
    flag(6'h00, 17'h02000, 16'h0001);
    flag(6'h04, 17'h02000, 16'h0000);
    flag(6'h04, 17'h01000, 16'h0002);
    flag(6'h04, 17'h00800, 16'h0004);
    flag(6'h00, 17'h00600, 16'h0008);
    flag(6'h00, 17'h00400, 16'h0000);
    flag(6'h00, 17'h00040, 16'h0010);
    flag(6'h00, 17'h00180, 16'h0020);
    flag(6'h0A, 17'h00010, 16'h0040);
    flag(6'h00, 17'h00020, 16'h0080);
    flag(6'h08, 17'h04000, 16'h0100);
    flag(6'h30, 17'h04000, 16'h0200);
    flag(6'h04, 17'h08000, 16'h0400);
    flag(6'h00, 17'h10000, 16'h0800);
    flag(6'h00, 17'h00008, 16'h2000);
    flag(6'h00, 17'h02008, 16'h2001);
    persist();
    dma(2'h3, 6'h05, 6'h03, 1'b1, 1'b1);
    dma(2'h3, 6'h06, 6'h02, 1'b0, 1'b0);
    dma(2'h3, 6'h20, 6'h00, 1'b0, 1'b0);
    dma(2'h2, 6'h00, 6'h09, 1'b1, 1'b0);
    dma(2'h1, 6'h00, 6'h09, 1'b0, 1'b1);
    lost(17'h00005, 1'b0, 16'h1000, 1, 0);
    lost(17'h00003, 1'b0, 16'h5000, 0, 1);
    lost(17'h00005, 1'b1, 16'h0000, 0, 0);
    summarize();
  end

  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule

bind i2cab_core i2cab_sva #(.LVL_W(LVL_W)) u_sva (
  .sys_clk(sys_clk), .reset(reset), .engine(engine),
  .tx_fifo_level(tx_fifo_level), .rx_fifo_level(rx_fifo_level),
  .transmit_abort_irq(transmit_abort_irq), .slave_tx_flush(slave_tx_flush),
  .master_bus_lost(master_bus_lost), .slave_bus_lost(slave_bus_lost),
  .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
`default_nettype wire
